// ==== design/tmcc_timer.sv ====
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// - Clear-on-match resets counter at compare 1
// - Run bit zero stops and clears counter
// - Counter overflow raises match/overflow interrupt
// - Two compare registers, each with comparator
// - Either compare match raises match interrupt
// - Double buffering off at reset, bit-controlled
// - Running buffers load actives on match one
// - Stopped counter: compare writes go direct
// - Two-bit field selects capture events
// - Writing zero to capture bit captures
// - Live count read samples while running
// - Toggle flop inverts on enabled events
// - Command field inverts, sets or clears flop
// - Toggle flop value unknown after reset
// - Toggle flop drives timer output pin
// - Capture latch raises its capture interrupt
// - DMA request on event when enabled
// - Match interrupt mask blocks compare-1 DMA
// - Pin source counts rising input edges
// - Counter is sixteen bits wide
// - Three-bit field selects source clock
module tmcc_timer (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire tmcc_pkg::tmcc_apb_req_s apb_req,
   output tmcc_pkg::tmcc_apb_rsp_s apb_rsp,
   input wire logic timer_input_pin,
   output logic timer_output_pin,
   output logic match_overflow_interrupt,
   output logic capture_interrupt_0,
   output logic capture_interrupt_1,
   output logic [2:0] dma_request
);
   import tmcc_pkg::*;

   tmcc_state_s q; // Registered state
   tmcc_state_s d; // Next state
   logic running; // Counter enabled to advance
   logic tick; // One counter step this cycle
   logic pin_rise; // Synchronised rising edge of the pin
   logic pin_fall; // Synchronised falling edge of the pin
   logic match0; // Compare 0 hit on a tick
   logic match1; // Compare 1 hit on a tick
   logic ovf; // Wrap from all ones on a tick
   logic cap0_ev; // Capture 0 latch event
   logic cap1_ev; // Capture 1 latch event
   logic sw_cap; // Software capture request
   logic toggle; // Odd number of enabled toggle sources firing
   logic wr; // Write accepted this edge
   logic rd_load; // Read data is being prepared
   logic [7:0] tap_mask; // Prescaler bits that must be all ones
   logic [31:0] wdat; // Shorthand for write data
   logic [31:0] rd_val; // Read value for the addressed register
   logic rd_hit; // Address decodes to a register

   // Pin edges read only the second and third flops, never the first
   assign pin_rise = q.pin_s & ~q.pin_d;
   assign pin_fall = ~q.pin_s & q.pin_d;
   assign running = q.blk_en & q.cnt_run;
   assign wdat = apb_req.pwdata;
   // Write lands on the edge where pready is seen high
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & q.ack;
   // First access cycle prepares read data, second one completes
   assign rd_load = apb_req.psel & apb_req.penable & ~q.ack;

   // Prescaler tap mask per source select
   always_comb begin
      unique case (q.clk_sel)
         3'h1: tap_mask = 8'h00;
         3'h2: tap_mask = 8'h03;
         3'h3: tap_mask = 8'h0F;
         3'h4: tap_mask = 8'h1F;
         3'h5: tap_mask = 8'h3F;
         3'h6: tap_mask = 8'h7F;
         default: tap_mask = 8'hFF;
      endcase
   end

   // Source clock selection: pin edge or prescaler tap
   always_comb begin
      if (q.clk_sel == SRC_PIN) begin
         tick = running & pin_rise;
      end else begin
         // Taps only count while the prescaler runs
         tick = running & q.pres_run & ((q.pres & tap_mask) == tap_mask);
      end
   end

   // Comparators and overflow, all sampled on the tick
   assign match0 = tick & (q.count == q.cmp0);
   assign match1 = tick & (q.count == q.cmp1);
   assign ovf = tick & (q.count == CNT_MAX) & ~(q.clr_match & match1);

   // Capture event selection
   assign sw_cap = wr & (apb_req.paddr == OFS_MODE) & ~wdat[BIT_SW_CAP];
   always_comb begin
      unique case (q.cap_sel)
         CAP_OFF: begin
            cap0_ev = 1'b0;
            cap1_ev = 1'b0;
         end
         CAP_PIN_EDGES: begin
            cap0_ev = running & pin_rise;
            cap1_ev = running & pin_fall;
         end
         CAP_MATCHES: begin
            cap0_ev = match0;
            cap1_ev = match1;
         end
         CAP_PIN_MATCH1: begin
            cap0_ev = running & pin_rise;
            cap1_ev = match1;
         end
      endcase
   end

   // Toggle sources, each gated by its own enable
   assign toggle = (match0 & q.tog_en[0]) ^ (match1 & q.tog_en[1])
      ^ ((cap0_ev | sw_cap) & q.tog_en[2]) ^ (cap1_ev & q.tog_en[3]);

   // Register read mux
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (apb_req.paddr)
         OFS_ENABLE: rd_val[BIT_BLK_EN] = q.blk_en;
         OFS_RUN: begin
            rd_val[BIT_CNT_RUN] = q.cnt_run;
            rd_val[BIT_PRES_RUN] = q.pres_run;
         end
         OFS_CTRL: rd_val[BIT_DBUF] = q.dbuf_en;
         OFS_MODE: rd_val[7:0] = {1'b0, 1'b1, q.cap_sel, q.clr_match, q.clk_sel};
         OFS_FFCR: rd_val[7:0] = {2'b00, q.tog_en, FF_KEEP};
         OFS_IMASK: rd_val[2:0] = q.imask;
         OFS_CMP0: rd_val[15:0] = q.cmp0;
         OFS_CMP1: rd_val[15:0] = q.cmp1;
         OFS_CAP0: rd_val[15:0] = q.cap0;
         OFS_CAP1: rd_val[15:0] = q.cap1;
         // Live count: fresh sample while running, last one when stopped
         OFS_LIVE: rd_val[15:0] = running ? q.count : q.live;
         OFS_DMA: rd_val[2:0] = q.dma_en;
         default: rd_hit = 1'b0;
      endcase
   end

   // Next-state logic for the whole channel
   always_comb begin
      d = q;
      // Two-flop synchroniser plus one delay for edge finding
      d.pin_meta = timer_input_pin;
      d.pin_s = q.pin_meta;
      d.pin_d = q.pin_s;
      // Free-running prescaler, held at zero while stopped
      d.pres = (q.blk_en & q.pres_run) ? q.pres + 8'h01 : 8'h00;
      // Counter step
      if (tick) begin
         if (q.clr_match && match1) begin
            d.count = CNT_ZERO;
         end else begin
            d.count = q.count + 16'h0001;
         end
      end
      // Buffers move into actives on a running compare-1 hit
      if (match1 && q.dbuf_en && running) begin
         d.cmp0 = q.buf0;
         d.cmp1 = q.buf1;
      end
      // Hardware captures
      if (cap0_ev) begin
         d.cap0 = q.count;
      end
      if (cap1_ev) begin
         d.cap1 = q.count;
      end
      d.tff = q.tff ^ toggle;
      // Event pulses, one cycle each
      d.irq_mo = (match0 & ~q.imask[0]) | (match1 & ~q.imask[1])
         | (ovf & ~q.imask[2]);
      d.irq_c0 = cap0_ev | sw_cap;
      d.irq_c1 = cap1_ev;
      d.dma_req[0] = (cap0_ev | sw_cap) & q.dma_en[0];
      d.dma_req[1] = cap1_ev & q.dma_en[1];
      // Mask on compare 1 also hides its DMA request
      d.dma_req[2] = match1 & q.dma_en[2] & ~q.imask[1];
      // Bus handshake: one wait cycle so read data comes from a flop
      d.ack = rd_load;
      d.slverr = 1'b0;
      if (rd_load) begin
         d.rdata = rd_hit ? rd_val : 32'h0000_0000;
         d.slverr = ~rd_hit;
         // A live read while counting stores the sample
         if (!apb_req.pwrite && apb_req.paddr == OFS_LIVE && running) begin
            d.live = q.count;
         end
      end
      // Software writes override hardware in the same cycle, except flop invert and keep commands, which combine with a hardware toggle
      if (wr) begin
         unique case (apb_req.paddr)
            OFS_ENABLE: d.blk_en = wdat[BIT_BLK_EN];
            OFS_RUN: begin
               d.cnt_run = wdat[BIT_CNT_RUN];
               d.pres_run = wdat[BIT_PRES_RUN];
               if (!wdat[BIT_CNT_RUN]) begin
                  d.count = CNT_ZERO;
               end
            end
            OFS_CTRL: d.dbuf_en = wdat[BIT_DBUF];
            OFS_MODE: begin
               d.clk_sel = wdat[2:0];
               d.clr_match = wdat[BIT_CLR_MATCH];
               d.cap_sel = wdat[POS_CAP_SEL +: 2];
               if (!wdat[BIT_SW_CAP]) begin
                  d.cap0 = q.count;
               end
            end
            OFS_FFCR: begin
               d.tog_en = wdat[POS_TOG_EN +: 4];
               unique case (wdat[1:0])
                  FF_INVERT: d.tff = ~(q.tff ^ toggle);
                  FF_SET: d.tff = 1'b1;
                  FF_CLEAR: d.tff = 1'b0;
                  FF_KEEP: d.tff = q.tff ^ toggle;
               endcase
            end
            OFS_IMASK: d.imask = wdat[2:0];
            OFS_CMP0: begin
               d.buf0 = wdat[15:0];
               // Single buffering when disabled or counter stopped
               if (!q.dbuf_en || !running) begin
                  d.cmp0 = wdat[15:0];
               end
            end
            OFS_CMP1: begin
               d.buf1 = wdat[15:0];
               if (!q.dbuf_en || !running) begin
                  d.cmp1 = wdat[15:0];
               end
            end
            OFS_DMA: d.dma_en = wdat[2:0];
            default: d.slverr = 1'b0;
         endcase
      end
      if (wr && !rd_hit) begin
         d.slverr = 1'b1;
      end
   end

   // State register; the toggle flop's reset value is not a promise
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs
   assign timer_output_pin = q.tff;
   assign match_overflow_interrupt = q.irq_mo;
   assign capture_interrupt_0 = q.irq_c0;
   assign capture_interrupt_1 = q.irq_c1;
   assign dma_request = q.dma_req;
   // One driver for the whole response, so no field is driven twice
   assign apb_rsp = '{
      prdata: q.rdata,
      pready: apb_req.psel & apb_req.penable & q.ack,
      pslverr: apb_req.psel & apb_req.penable & q.ack & (q.slverr | ~rd_hit)
   };

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_stop_clears: assert property (
      wr && apb_req.paddr == OFS_RUN && !wdat[BIT_CNT_RUN] |=> q.count == CNT_ZERO && !q.cnt_run)
      else $error("count not cleared on stop");
   a_clear_match: assert property (
      match1 && q.clr_match && !(wr && apb_req.paddr == OFS_RUN) |=> q.count == CNT_ZERO)
      else $error("count not cleared on compare 1");
   a_overflow_irq: assert property (
      ovf && !q.imask[2] |=> match_overflow_interrupt)
      else $error("overflow interrupt missing");
   a_match_irq: assert property (
      match0 && !q.imask[0] |=> match_overflow_interrupt)
      else $error("match interrupt missing");
   a_dbuf_load: assert property (
      match1 && q.dbuf_en && running && !wr |=> q.cmp1 == $past(q.buf1) && q.cmp0 == $past(q.buf0))
      else $error("buffers not transferred");
   a_direct_write: assert property (
      wr && apb_req.paddr == OFS_CMP0 && !running |=> q.cmp0 == $past(wdat[15:0]))
      else $error("stopped compare write not direct");
   a_sw_capture: assert property (
      sw_cap |=> q.cap0 == $past(q.count) && capture_interrupt_0)
      else $error("software capture failed");
   a_cap1_irq: assert property (
      cap1_ev && !wr |=> capture_interrupt_1 && q.cap1 == $past(q.count))
      else $error("capture 1 event lost");
   a_dma_mask: assert property (
      match1 && q.imask[1] |=> !dma_request[2])
      else $error("masked compare 1 DMA issued");
   a_ff_command: assert property (
      wr && apb_req.paddr == OFS_FFCR && wdat[1:0] == FF_SET ##1 !toggle |=> timer_output_pin)
      else $error("flop set command ignored");
   a_pin_count: assert property (
      q.clk_sel == SRC_PIN && !running |=> $stable(q.count) || $past(wr))
      else $error("stopped pin counter moved");
endmodule

// ==== design/tmcc_pkg.sv ====
package tmcc_pkg;
   // Register byte offsets on the APB slave
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_RUN = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_FFCR = 8'h10;
   localparam logic [7:0] OFS_IMASK = 8'h18;
   localparam logic [7:0] OFS_CMP0 = 8'h1C;
   localparam logic [7:0] OFS_CMP1 = 8'h20;
   localparam logic [7:0] OFS_CAP0 = 8'h24;
   localparam logic [7:0] OFS_CAP1 = 8'h28;
   localparam logic [7:0] OFS_LIVE = 8'h2C;
   localparam logic [7:0] OFS_DMA = 8'h30;
   // Field positions
   localparam int BIT_BLK_EN = 7;
   localparam int BIT_CNT_RUN = 0;
   localparam int BIT_PRES_RUN = 2;
   localparam int BIT_DBUF = 7;
   localparam int BIT_CLR_MATCH = 3;
   localparam int BIT_SW_CAP = 6;
   localparam int POS_CAP_SEL = 4;
   localparam int POS_TOG_EN = 2;
   // Toggle flop commands
   localparam logic [1:0] FF_INVERT = 2'h0;
   localparam logic [1:0] FF_SET = 2'h1;
   localparam logic [1:0] FF_CLEAR = 2'h2;
   localparam logic [1:0] FF_KEEP = 2'h3;
   // Capture timing selections
   localparam logic [1:0] CAP_OFF = 2'h0;
   localparam logic [1:0] CAP_PIN_EDGES = 2'h1;
   localparam logic [1:0] CAP_MATCHES = 2'h2;
   localparam logic [1:0] CAP_PIN_MATCH1 = 2'h3;
   // Source clock select: 0 is the input pin, 1..7 prescaler taps
   localparam logic [2:0] SRC_PIN = 3'h0;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   // APB request and response
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } tmcc_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tmcc_apb_rsp_s;

   // Whole state of the timer channel
   typedef struct packed {
      logic pin_meta;
      logic pin_s;
      logic pin_d;
      logic [7:0] pres;
      logic blk_en;
      logic cnt_run;
      logic pres_run;
      logic dbuf_en;
      logic [2:0] clk_sel;
      logic clr_match;
      logic [1:0] cap_sel;
      logic [3:0] tog_en;
      logic [2:0] imask;
      logic [2:0] dma_en;
      logic [15:0] count;
      logic [15:0] cmp0;
      logic [15:0] cmp1;
      logic [15:0] buf0;
      logic [15:0] buf1;
      logic [15:0] cap0;
      logic [15:0] cap1;
      logic [15:0] live;
      logic tff;
      logic irq_mo;
      logic irq_c0;
      logic irq_c1;
      logic [2:0] dma_req;
      logic ack;
      logic [31:0] rdata;
      logic slverr;
   } tmcc_state_s;
endpackage

// ==== tb/tmcc_pin_src.sv ====
`timescale 1ns/10ps
// Event source on the timer input pin; the line idles low between bursts
module tmcc_pin_src (
   input wire logic sys_clk,
   output logic timer_input_pin
);
   // Known level from time zero
   initial timer_input_pin = 1'b0;

   // Burst of n rising edges, high held gap cycles, low held gap + 1 cycles
   // A zero gap never drives the pin high; one cycle is enough for the synchroniser, and callers keep gap >= 2
   task automatic pulse(input int n, input int gap);
      repeat (n) begin
         @(posedge sys_clk);
         timer_input_pin <= 1'b1;
         repeat (gap) @(posedge sys_clk);
         timer_input_pin <= 1'b0;
         repeat (gap) @(posedge sys_clk);
      end
   endtask
endmodule

// ==== tb/tmcc_timer_tb_top.sv ====
`timescale 1ns/10ps
module tmcc_timer_tb_top;
   import tmcc_pkg::*;
   logic sys_clk;
   logic resetn;
   tmcc_apb_req_s req; // Bus request from the bench
   tmcc_apb_rsp_s rsp; // Bus answer from the timer
   logic pin; // Event line from the source model
   logic tout; // Toggle flop level
   logic irq_mo;
   logic irq_c0;
   logic irq_c1;
   logic [2:0] dma;
   logic [31:0] rd; // Data of the last transfer
   logic err; // Error flag of the last transfer
   logic v; // Saved flop level
   logic [31:0] held; // Live count seen while running
   int num_errors;
   int n_compared;
   int n_mo; // Pulse tallies
   int n_c0;
   int n_d0;
   int n_d2;
   int n; // Tally snapshot
   int g; // Cycles between interrupts
   // Flop commands and the level each leaves behind
   localparam logic [1:0] FFC [5] = '{FF_SET, FF_CLEAR, FF_INVERT, FF_INVERT, FF_KEEP};
   localparam logic FFV [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

   tmcc_timer i_dut (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .apb_req(req),
      .apb_rsp(rsp),
      .timer_input_pin(pin),
      .timer_output_pin(tout),
      .match_overflow_interrupt(irq_mo),
      .capture_interrupt_0(irq_c0),
      .capture_interrupt_1(irq_c1),
      .dma_request(dma)
   );
   tmcc_pin_src i_src (
      .sys_clk(sys_clk),
      .timer_input_pin(pin)
   );

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   // Tally one-cycle pulses at the edge, so each is counted once
   always @(posedge sys_clk) begin
      n_mo <= n_mo + (irq_mo === 1'b1);
      n_c0 <= n_c0 + (irq_c0 === 1'b1);
      n_d0 <= n_d0 + (dma[0] === 1'b1);
      n_d2 <= n_d2 + (dma[2] === 1'b1);
   end

   // Count and report one comparison
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One bus transfer; request held until pready is seen high, then released
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int t;
      t = 0;
      @(posedge sys_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      #1;
      // Wait state count is not assumed; only the bound ends a hang
      while (rsp.pready !== 1'b1 && t < 50) begin
         @(posedge sys_clk);
         #1;
         t++;
      end
      if (t == 50) begin
         num_errors++;
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      @(posedge sys_clk);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask

   // Cycles until the next match/overflow pulse, bounded for the overflow case
   task automatic wait_irq(output int c);
      c = 0;
      do begin
         @(posedge sys_clk);
         #1;
         c++;
      end while (irq_mo !== 1'b1 && c < 70000);
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog well past the overflow run
   initial begin
      repeat (90000) @(posedge sys_clk);
      num_errors++;
      summarize();
   end

   // Main sequence
   initial begin
      sys_clk = 1'b0;
      resetn = 1'b0;
      req = '0;
      {num_errors, n_compared, n_mo, n_c0, n_d0, n_d2} = '0;
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      rdc("ctrl", OFS_CTRL, 32'h0);
      rdc("dma", OFS_DMA, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      // Flop commands act at once; flop forced before any reliance on it
      foreach (FFC[i]) begin
         wrr(OFS_FFCR, {30'h0, FFC[i]});
         repeat (2) @(posedge sys_clk);
         chk("flop", {31'h0, FFV[i]}, {31'h0, tout});
      end
      // Interval timer, period 10; compare 0 masked since it also matches at 0
      wrr(OFS_RUN, 32'h0);
      wrr(OFS_ENABLE, 32'h80);
      wrr(OFS_FFCR, 32'h0B);
      wrr(OFS_IMASK, 32'h1);
      wrr(OFS_DMA, 32'h7);
      wrr(OFS_MODE, 32'h69);
      wrr(OFS_CMP1, 32'h9);
      wrr(OFS_RUN, 32'h5);
      wait_irq(g);
      v = tout;
      wait_irq(g);
      chk("period", 32'd10, g);
      chk("toggle", {31'h0, ~v}, {31'h0, tout});
      chk("dma2", 32'h1, {31'h0, dma[2]});
      chk("dma1", 32'h1, {31'h0, dma[1]});
      chk("cap1 irq", 32'h1, {31'h0, irq_c1});
      rdc("cap1", OFS_CAP1, 32'h9);
      // Masking compare 1 silences both its interrupt and its request
      wrr(OFS_IMASK, 32'h3);
      // Let a pulse launched with the old mask drain into the tallies first
      repeat (2) @(posedge sys_clk);
      n = n_d2 + n_mo;
      repeat (30) @(posedge sys_clk);
      chk("masked", n, n_d2 + n_mo);
      apb(1'b0, OFS_LIVE, 32'h0);
      held = rd;
      chk("live", 32'h1, {31'h0, held <= 32'h9});
      wrr(OFS_RUN, 32'h0);
      rdc("live held", OFS_LIVE, held);
      n = n_c0 + n_d0;
      wrr(OFS_MODE, 32'h29);
      repeat (3) @(posedge sys_clk);
      rdc("cap0 stop", OFS_CAP0, 32'h0);
      chk("cap0 pulse", n + 2, n_c0 + n_d0);
      // Double buffer: direct while stopped, buffered while running
      wrr(OFS_CTRL, 32'h80);
      wrr(OFS_CMP1, 32'h5);
      // Divide-by-four tap, so each count step takes four cycles
      wrr(OFS_MODE, 32'h4A);
      wrr(OFS_IMASK, 32'h1);
      wrr(OFS_RUN, 32'h5);
      wait_irq(g);
      wait_irq(g);
      chk("direct", 32'd24, g);
      wrr(OFS_CMP1, 32'h13);
      wait_irq(g);
      wait_irq(g);
      chk("buffered", 32'd80, g);
      // Full wrap with no clear; only overflow unmasked
      wrr(OFS_RUN, 32'h0);
      wrr(OFS_CTRL, 32'h0);
      wrr(OFS_MODE, 32'h41);
      wrr(OFS_IMASK, 32'h3);
      wrr(OFS_RUN, 32'h5);
      wait_irq(g);
      chk("overflow", 32'h1, {31'h0, g >= 65536 && g <= 65540});
      // Event counter from the pin, read back through a software capture
      wrr(OFS_RUN, 32'h0);
      // Pin source with pin-edge captures: capture 1 takes the count on each fall
      wrr(OFS_MODE, 32'h50);
      wrr(OFS_RUN, 32'h5);
      i_src.pulse(5, 3);
      repeat (6) @(posedge sys_clk);
      wrr(OFS_MODE, 32'h00);
      rdc("events", OFS_CAP0, 32'h5);
      rdc("pin cap1", OFS_CAP1, 32'h5);
      summarize();
   end
endmodule
